// >>> hdl/port_pin_mode_pkg.sv
/*
 * Constants for the port two pin function configuration block.
 * Assumes an 8-bit register bank reached over a plain address/strobe port.
 */
// Functional notes
// R1 - Write with pointer-load clear stores mode field into selected pin's mode.
// R2 - Direction bit zero targets output configuration, one targets input configuration.
// R3 - Output modes: 000 normal drive, 011 high drive; others illegal.
// R4 - Input modes in low two bits: none, pull-down, pull-up, buffer off.
// R5 - Write with pointer-load set saves pin select and direction as read pointer.
// R6 - Mode field ignored entirely when pointer-load bit is set.
// R7 - Read returns mode of saved pin, direction chosen by saved direction bit.
// R8 - Three-bit pin select picks one of eight pins for a mode write.
// R9 - Pin select codes map in binary order, 000 to pin zero.
// R10 - Separate output and input storage per pin; writes touch only one entry.
package port_pin_mode_pkg;
    // ************************************************************
    // Register map and field layout
    // ************************************************************
    localparam logic [7:0] PORT_TWO_PIN_CONFIG_ADDR = 8'h97;
    localparam logic [7:0] PORT_TWO_PIN_CONFIG_RESET = 8'h00;
    localparam int MODE_FIELD_HI = 7;
    localparam int MODE_FIELD_LO = 5;
    localparam int DIRECTION_BIT = 4;
    localparam int READ_POINTER_LOAD_BIT = 3;
    localparam int PIN_SELECT_HI = 2;
    localparam int PIN_SELECT_LO = 0;
    // ************************************************************
    // Mode codes and reset values
    // ************************************************************
    localparam logic [2:0] OUT_MODE_NORMAL = 3'h0;
    localparam logic [2:0] OUT_MODE_HIGH = 3'h3;
    localparam logic [1:0] IN_MODE_NO_PULL = 2'h0;
    localparam logic [1:0] IN_MODE_PULL_DOWN = 2'h1;
    localparam logic [1:0] IN_MODE_PULL_UP = 2'h2;
    localparam logic [1:0] IN_MODE_BUFFER_OFF = 2'h3;
    localparam logic [2:0] OUT_MODE_RESET = 3'h0;
    localparam logic [1:0] IN_MODE_RESET = 2'h0;
    localparam logic [2:0] POINTER_PIN_RESET = 3'h0;
    localparam logic POINTER_DIR_RESET = 1'b0;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
endpackage : port_pin_mode_pkg

// >>> hdl/port_pin_mode_config.sv
/*
 * Pin function configuration for an eight-pin port behind one indirectly
 * addressed register. A write either updates one pin's output or input
 * mode, or loads the read pointer; a read returns the mode that the
 * pointer selects. Every pin keeps its own output and input mode.
 *
 * Assumes one clock, a synchronous active-low reset, and a register
 * master that gives one-cycle strobes, never both at once, and takes
 * read data in the cycle after the read strobe and only there.
 * Pad electrical behaviour and the decoding of illegal output codes
 * live outside this block.
 */
`timescale 1ns/1ps
module port_pin_mode_config #(
    parameter int PIN_COUNT = 8
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    output logic [7:0] rdata_out,
    // Per-pin modes toward the pads
    output logic [PIN_COUNT*3-1:0] out_mode_out,
    output logic [PIN_COUNT*2-1:0] in_mode_out
);
    // ************************************************************
    // Field decoding
    // ************************************************************
    // Address match shared by the write and the read path
    function automatic logic is_config_addr(input logic [7:0] addr);
        is_config_addr = (addr == port_pin_mode_pkg::PORT_TWO_PIN_CONFIG_ADDR);
    endfunction : is_config_addr

    function automatic logic [2:0] pin_field(input logic [7:0] data);
        pin_field = data[port_pin_mode_pkg::PIN_SELECT_HI:port_pin_mode_pkg::PIN_SELECT_LO];
    endfunction : pin_field

    function automatic logic [2:0] mode_field(input logic [7:0] data);
        mode_field = data[port_pin_mode_pkg::MODE_FIELD_HI:port_pin_mode_pkg::MODE_FIELD_LO];
    endfunction : mode_field

    function automatic logic dir_field(input logic [7:0] data);
        dir_field = data[port_pin_mode_pkg::DIRECTION_BIT];
    endfunction : dir_field

    function automatic logic load_field(input logic [7:0] data);
        load_field = data[port_pin_mode_pkg::READ_POINTER_LOAD_BIT];
    endfunction : load_field

    // One bit per pin; codes past the last pin select nothing
    function automatic logic [PIN_COUNT-1:0] pin_onehot(input logic [2:0] pin);
        pin_onehot = '0;
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (pin == 3'(i)) begin
                pin_onehot[i] = 1'b1; // R9
            end
        end
    endfunction : pin_onehot

    // Mode code in the top field, lower bits read as zero
    function automatic logic [7:0] read_word(input logic [2:0] mode);
        read_word = {mode, 5'h00};
    endfunction : read_word

    // ************************************************************
    // Decoded strobes and fields
    // ************************************************************
    logic write_hit;
    logic read_hit;
    logic mode_write;
    logic ptr_write;
    logic [2:0] wr_pin;
    logic wr_dir;
    logic [2:0] wr_mode;
    logic [PIN_COUNT-1:0] wr_pin_onehot;

    assign write_hit = write_in && is_config_addr(addr_in);
    assign read_hit = read_in && is_config_addr(addr_in);
    assign ptr_write = write_hit && load_field(wdata_in); // R5
    assign mode_write = write_hit && !load_field(wdata_in); // R1
    assign wr_pin = pin_field(wdata_in); // R8
    assign wr_dir = dir_field(wdata_in); // R2
    // Only mode writes consume this; pointer loads never look at it
    assign wr_mode = mode_field(wdata_in); // R6
    assign wr_pin_onehot = pin_onehot(wr_pin); // R8

    // ************************************************************
    // Read pointer
    // ************************************************************
    logic [2:0] ptr_pin_reg;
    logic [2:0] ptr_pin_next;
    logic ptr_dir_reg;
    logic ptr_dir_next;

    always_comb begin
        ptr_pin_next = ptr_pin_reg;
        ptr_dir_next = ptr_dir_reg;
        if (ptr_write) begin
            ptr_pin_next = wr_pin; // R5
            ptr_dir_next = wr_dir; // R5
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            ptr_pin_reg <= port_pin_mode_pkg::POINTER_PIN_RESET;
            ptr_dir_reg <= port_pin_mode_pkg::POINTER_DIR_RESET;
        end else begin
            ptr_pin_reg <= ptr_pin_next;
            ptr_dir_reg <= ptr_dir_next;
        end
    end

    // ************************************************************
    // Per-pin mode storage
    // ************************************************************
    // Views of every pin's modes for the read multiplexer
    logic [2:0] out_mode_view [PIN_COUNT];
    logic [1:0] in_mode_view [PIN_COUNT];

    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++) begin : g_pin
            logic pin_hit;
            logic [2:0] out_mode_reg;
            logic [2:0] out_mode_next;
            logic [1:0] in_mode_reg;
            logic [1:0] in_mode_next;

            // Only the selected pin sees a write; the rest hold
            assign pin_hit = mode_write && wr_pin_onehot[g]; // R10

            always_comb begin
                out_mode_next = out_mode_reg;
                in_mode_next = in_mode_reg;
                if (pin_hit) begin
                    if (wr_dir) begin
                        // Top bit of the field has no meaning for input modes
                        in_mode_next = wr_mode[1:0]; // R4
                    end else begin
                        // Illegal codes stored as written; the pad decodes them
                        out_mode_next = wr_mode; // R3
                    end
                end
            end

            always_ff @(posedge clock_in) begin
                if (!rst_b_in) begin
                    out_mode_reg <= port_pin_mode_pkg::OUT_MODE_RESET;
                    in_mode_reg <= port_pin_mode_pkg::IN_MODE_RESET;
                end else begin
                    out_mode_reg <= out_mode_next;
                    in_mode_reg <= in_mode_next;
                end
            end

            assign out_mode_view[g] = out_mode_reg;
            assign in_mode_view[g] = in_mode_reg;
        end
    endgenerate

    // ************************************************************
    // Pad outputs
    // ************************************************************
    genvar p;
    generate
        for (p = 0; p < PIN_COUNT; p++) begin : g_pad
            assign out_mode_out[p*3 +: 3] = out_mode_view[p];
            assign in_mode_out[p*2 +: 2] = in_mode_view[p];
        end
    endgenerate

    // ************************************************************
    // Read data
    // ************************************************************
    logic [1:0] sel_in_mode;
    logic [2:0] sel_out_mode;
    logic [PIN_COUNT-1:0] ptr_pin_onehot;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    assign ptr_pin_onehot = pin_onehot(ptr_pin_reg);

    // AND-OR select keeps a pointer past the last pin reading as zero
    always_comb begin
        sel_in_mode = 2'h0;
        sel_out_mode = 3'h0;
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (ptr_pin_onehot[i]) begin
                sel_in_mode = in_mode_view[i];
                sel_out_mode = out_mode_view[i];
            end
        end
    end

    always_comb begin
        rdata_next = port_pin_mode_pkg::UNMAPPED_READ_VALUE;
        if (read_hit) begin
            if (ptr_dir_reg) begin
                rdata_next = read_word({1'b0, sel_in_mode}); // R7
            end else begin
                rdata_next = read_word(sel_out_mode); // R7
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            rdata_reg <= port_pin_mode_pkg::UNMAPPED_READ_VALUE;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Read data stands for one cycle only, then returns to zero
    assign rdata_out = rdata_reg;
endmodule : port_pin_mode_config

// >>> tb/port_pin_mode_chk.sv
/* Port checks for the pin mode block; bound to its top, one clock domain. */
`timescale 1ns/1ps
module port_pin_mode_chk #(parameter int PIN_COUNT = 8) (
    input wire logic clock_in, rst_b_in, write_in, read_in,
    input wire logic [7:0] addr_in, wdata_in, rdata_out,
    input wire logic [PIN_COUNT*3-1:0] out_mode_out,
    input wire logic [PIN_COUNT*2-1:0] in_mode_out);
    wire hit = addr_in == 8'h97;
    wire rd = read_in && hit;
    wire [PIN_COUNT*5-1:0] modes = {out_mode_out, in_mode_out};
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    sequence wr(d); write_in && hit && !wdata_in[3] && wdata_in[4] == d; endsequence
    sequence ld; write_in && hit && wdata_in[3]; endsequence
    a_out_wr: assert property (wr(0) |=>
        out_mode_out[$past(wdata_in[2:0])*3+:3] == $past(wdata_in[7:5])) else $error("out");
    a_in_wr: assert property (wr(1) |=>
        in_mode_out[$past(wdata_in[2:0])*2+:2] == $past(wdata_in[6:5])) else $error("in");
    a_in_kept: assert property (wr(0) |=> $stable(in_mode_out)) else $error("in");
    a_out_kept: assert property (wr(1) |=> $stable(out_mode_out)) else $error("out");
    a_load_kept: assert property (ld |=> $stable(modes)) else $error("load");
    a_foreign_kept: assert property (write_in && !hit |=> $stable(modes)) else $error("addr");
    a_rd_low: assert property (rd |=> rdata_out[4:0] == 5'h00) else $error("low");
    a_rd_idle: assert property (!rd |=> rdata_out == 8'h00) else $error("idle");
endmodule : port_pin_mode_chk
bind port_pin_mode_config port_pin_mode_chk #(.PIN_COUNT(PIN_COUNT)) chk (.*);

// >>> tb/test_port_pin_mode_config.sv
/* Bench for the pin mode block; drives its register port directly. */
`timescale 1ns/1ps
module test_port_pin_mode_config;
    logic clock_in = 0, rst_b_in = 0, write_in = 0, read_in = 0;
    logic [7:0] addr_in = 8'h97, wdata_in = 8'h00, rdata_out;
    logic [23:0] out_mode_out;
    logic [15:0] in_mode_out;
    int errors = 0, tests_run = 0;
    logic [23:0] row [5] = '{24'h600860, 24'h670F60, 24'h311920, 24'h521A40, 24'hF30B00};
    port_pin_mode_config dut (.*);
    initial forever #50 clock_in = ~clock_in;
    initial begin
        #100000 errors++;
        final_report;
    end
    task final_report;
        if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task chk(input logic [39:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task op(input logic r, input logic [7:0] a, d);
        @(posedge clock_in);
        {addr_in, wdata_in} <= {a, d};
        {write_in, read_in} <= {!r, r};
        @(posedge clock_in);
        {write_in, read_in} <= 2'h0;
        @(negedge clock_in);
        if (r) chk(rdata_out, d);
    endtask : op
    initial begin
        repeat (5) @(posedge clock_in);
        rst_b_in <= 1'b1;
        foreach (row[i]) for (int j = 0; j < 3; j++)
            op(j == 2, 8'h97, row[i][23-8*j-:8]);
        op(0, 8'h97, 8'hFB);
        op(1, 8'h97, 8'h60);
        op(0, 8'h96, 8'h65);
        op(1, 8'h96, 8'h00);
        chk({out_mode_out, in_mode_out}, 40'h60000300E4);
        repeat (2) @(posedge clock_in) rst_b_in <= 1'b0;
        @(posedge clock_in) rst_b_in <= 1'b1;
        op(1, 8'h97, 8'h00);
        chk({out_mode_out, in_mode_out}, 40'h0000000000);
        final_report;
    end
endmodule : test_port_pin_mode_config
